// ---- asc_pkg.sv ----
// Shared constants of the audio serial port clock configuration block.
// Assumes a single 100 MHz clock domain and byte-wide register access.
package asc_pkg;

    // =========================================================================
    // Register offsets
    // =========================================================================
    localparam logic [7:0] CHAN8_SLOT_CONFIG_ADDR         = 8'h12;
    localparam logic [7:0] PORT_ROLE_CLOCK_CONFIG_ADDR    = 8'h13;
    localparam logic [7:0] PORT_RATE_RATIO_CONFIG_ADDR    = 8'h14;
    localparam logic [7:0] PORT_CLOCK_MONITOR_STATUS_ADDR = 8'h15;
    localparam logic [7:0] CLOCK_ROOT_CONFIG_ADDR         = 8'h16;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic [7:0] CHAN8_SLOT_CONFIG_RST         = 8'h07;
    localparam logic [7:0] PORT_ROLE_CLOCK_CONFIG_RST    = 8'h02;
    localparam logic [7:0] PORT_RATE_RATIO_CONFIG_RST    = 8'h48;
    localparam logic [7:0] PORT_CLOCK_MONITOR_STATUS_RST = 8'hff;
    localparam logic [7:0] CLOCK_ROOT_CONFIG_RST         = 8'h00;

    // =========================================================================
    // Field positions and writable masks
    // =========================================================================
    localparam int         LINE_SELECT_BIT   = 6;
    localparam int         ROLE_SELECT_BIT   = 7;
    localparam int         AUTO_OFF_BIT      = 6;
    localparam int         AUTO_PLL_OFF_BIT  = 5;
    localparam int         CLOCK_GATE_BIT    = 4;
    localparam int         RATE_FAMILY_BIT   = 3;
    localparam int         ROOT_SOURCE_BIT   = 7;
    localparam int         SELECT_METHOD_BIT = 6;
    localparam logic [7:0] CHAN8_WR_MASK     = 8'h7f;
    localparam logic [7:0] ROOT_WR_MASK      = 8'hc0;

    // =========================================================================
    // Codes and timing
    // =========================================================================
    localparam logic [3:0]  INVALID_CODE     = 4'hf;
    localparam int          RATE_CODES       = 9;
    localparam int          RATIO_CODES      = 13;
    localparam logic [3:0]  FALLBACK_RATIO   = 4'h8;
    // Half period of the generated bit clock in CLK cycles.
    localparam logic [7:0]  BCLK_HALF_CYCLES = 8'h02;
    localparam logic [15:0] FRAME_TIMEOUT    = 16'hffff;

    // Frame period windows in CLK cycles, covering both rate families.
    localparam logic [15:0] RATE_LO [0:8] = '{16'h2e63, 16'h1731, 16'h0f76, 16'h0b98, 16'h07bb,
                                              16'h03dd, 16'h01ef, 16'h00f7, 16'h007b};
    localparam logic [15:0] RATE_HI [0:8] = '{16'h37ce, 16'h1be7, 16'h129a, 16'h0df3, 16'h094d,
                                              16'h04a6, 16'h0253, 16'h012a, 16'h0095};
    // Bit clocks per frame for each ratio code.
    localparam logic [11:0] RATIO_VAL [0:12] = '{12'h010, 12'h018, 12'h020, 12'h030, 12'h040,
                                                 12'h060, 12'h080, 12'h0c0, 12'h100, 12'h180,
                                                 12'h200, 12'h400, 12'h800};

endpackage : asc_pkg

// ---- asc_port_config.sv ----
// Register file, serial clock generator and clock monitor of the audio port.
// Assumes registers are written and read over a byte-wide strobe port and
// that the bit clock and frame sync pins arrive asynchronously to CLK.
//
// Function
// RULE1 - Line-select bit moves channel 8 between primary and secondary output.
// RULE2 - Six-bit slot field; in I2S/LJ codes 32-63 pick right slots.
// RULE3 - Channel 8 slot field resets to seven.
// RULE4 - Role bit clear: clocks are inputs; set: device drives both clocks.
// RULE5 - Auto-configuration-off bit disables automatic divider and PLL derivation.
// RULE6 - In auto mode the PLL runs unless the auto-PLL-off bit is set.
// RULE7 - Gate bit forces generated bit clock and frame sync low in controller role.
// RULE8 - Rate-family bit picks 48 kHz or 44.1 kHz family in controller role.
// RULE9 - Three-bit reference frequency code, reset two, used with frequency selection.
// RULE10 - Four-bit frame rate code, reset four, ignored in target auto mode.
// RULE11 - Four-bit ratio code, reset eight, ignored in target auto mode.
// RULE12 - Read-only clock monitor status at 0x15 resets to all ones.
// RULE13 - Upper status nibble reports detected rate, fifteen when invalid.
// RULE14 - Lower status nibble reports detected ratio, fifteen when invalid.
// RULE15 - Selection-method bit picks frequency code or frame-sync multiple reference.
// RULE16 - Target auto mode without PLL takes root from bit or reference clock.
// RULE17 - Reserved bits read zero and writes to them do nothing.
// RULE18 - In target role clock pins are inputs regardless of gate settings.
`timescale 1ns/1ps

module asc_port_config (
    // Clock, reset and enable
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       CE,
    // Register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WE,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // Serial clock pins
    input  wire logic       BCLK_I,
    output logic            BCLK_O,
    output logic            BCLK_OE,
    input  wire logic       FRAME_SYNC_I,
    output logic            FRAME_SYNC_O,
    output logic            FRAME_SYNC_OE,
    // Channel 8 placement
    output logic            CHAN8_LINE_SELECT,
    output logic      [5:0] CHAN8_SLOT_INDEX,
    output logic            CHAN8_RIGHT_HALF,
    // Clock tree controls
    output logic            AUTO_CLOCK_ACTIVE,
    output logic            PLL_ENABLE,
    output logic            RATE_FAMILY_SELECT,
    output logic            REF_BY_FREQ_CODE,
    output logic      [2:0] REF_CLOCK_FREQ_CODE,
    output logic            RATE_RATIO_USED,
    output logic      [3:0] FRAME_RATE_CODE,
    output logic      [3:0] BITCLK_FRAME_RATIO_CODE,
    output logic            ROOT_FROM_REF
);

    // =========================================================================
    // Lookup functions
    // =========================================================================
    // Maps a measured frame period to a rate code.
    function automatic logic [3:0] rate_lookup(input logic [15:0] period);
        logic [3:0] code;
        code = asc_pkg::INVALID_CODE;
        for (int i = 0; i < asc_pkg::RATE_CODES; i++) begin
            if (period >= asc_pkg::RATE_LO[i] && period <= asc_pkg::RATE_HI[i]) begin
                code = 4'(i);
            end
        end
        return code;
    endfunction : rate_lookup

    // Maps a bit clock count per frame to a ratio code.
    function automatic logic [3:0] ratio_lookup(input logic [11:0] count);
        logic [3:0] code;
        code = asc_pkg::INVALID_CODE;
        for (int i = 0; i < asc_pkg::RATIO_CODES; i++) begin
            if (count == asc_pkg::RATIO_VAL[i]) begin
                code = 4'(i);
            end
        end
        return code;
    endfunction : ratio_lookup

    // =========================================================================
    // Registers
    // =========================================================================
    logic [7:0]  chan8_reg;
    logic [7:0]  role_reg;
    logic [7:0]  rate_ratio_reg;
    logic [7:0]  status_reg;
    logic [7:0]  root_reg;

    // Address decode and field views.
    wire         wr_chan8      = CE && REG_WE && REG_ADDR == asc_pkg::CHAN8_SLOT_CONFIG_ADDR;
    wire         wr_role       = CE && REG_WE && REG_ADDR == asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR;
    wire         wr_rate       = CE && REG_WE && REG_ADDR == asc_pkg::PORT_RATE_RATIO_CONFIG_ADDR;
    wire         wr_root       = CE && REG_WE && REG_ADDR == asc_pkg::CLOCK_ROOT_CONFIG_ADDR;
    wire         role_ctrl     = role_reg[asc_pkg::ROLE_SELECT_BIT];
    wire         auto_on       = !role_reg[asc_pkg::AUTO_OFF_BIT];
    wire         auto_pll_off  = role_reg[asc_pkg::AUTO_PLL_OFF_BIT];
    wire         clock_gate    = role_reg[asc_pkg::CLOCK_GATE_BIT];
    wire [3:0]   ratio_field   = rate_ratio_reg[3:0];

    // Register writes; reserved bits are masked so they never store.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            // RULE3 slot resets seven
            chan8_reg      <= asc_pkg::CHAN8_SLOT_CONFIG_RST;
            role_reg       <= asc_pkg::PORT_ROLE_CLOCK_CONFIG_RST;
            rate_ratio_reg <= asc_pkg::PORT_RATE_RATIO_CONFIG_RST;
            root_reg       <= asc_pkg::CLOCK_ROOT_CONFIG_RST;
        end else begin
            // RULE17 reserved bits masked
            if (wr_chan8) chan8_reg <= REG_WDATA & asc_pkg::CHAN8_WR_MASK;
            if (wr_role)  role_reg <= REG_WDATA;
            if (wr_rate)  rate_ratio_reg <= REG_WDATA;
            if (wr_root)  root_reg <= REG_WDATA & asc_pkg::ROOT_WR_MASK;
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    logic [7:0] rdata_next;
    always_comb begin
        case (REG_ADDR)
            asc_pkg::CHAN8_SLOT_CONFIG_ADDR:         rdata_next = chan8_reg;
            asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR:    rdata_next = role_reg;
            asc_pkg::PORT_RATE_RATIO_CONFIG_ADDR:    rdata_next = rate_ratio_reg;
            // RULE12 status read only
            asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR: rdata_next = status_reg;
            asc_pkg::CLOCK_ROOT_CONFIG_ADDR:         rdata_next = root_reg;
            default:                                 rdata_next = 8'h00;
        endcase
    end

    // =========================================================================
    // Decoded control outputs
    // =========================================================================
    always_ff @(posedge CLK) begin
        if (RESET) begin
            REG_RDATA               <= 8'h00;
            CHAN8_LINE_SELECT       <= 1'b0;
            CHAN8_SLOT_INDEX        <= asc_pkg::CHAN8_SLOT_CONFIG_RST[5:0];
            CHAN8_RIGHT_HALF        <= 1'b0;
            AUTO_CLOCK_ACTIVE       <= 1'b1;
            PLL_ENABLE              <= 1'b1;
            RATE_FAMILY_SELECT      <= 1'b0;
            REF_BY_FREQ_CODE        <= 1'b0;
            REF_CLOCK_FREQ_CODE     <= asc_pkg::PORT_ROLE_CLOCK_CONFIG_RST[2:0];
            RATE_RATIO_USED         <= 1'b0;
            FRAME_RATE_CODE         <= asc_pkg::PORT_RATE_RATIO_CONFIG_RST[7:4];
            BITCLK_FRAME_RATIO_CODE <= asc_pkg::PORT_RATE_RATIO_CONFIG_RST[3:0];
            ROOT_FROM_REF           <= 1'b0;
        end else if (CE) begin
            REG_RDATA               <= rdata_next;
            // RULE1 channel 8 line
            CHAN8_LINE_SELECT       <= chan8_reg[asc_pkg::LINE_SELECT_BIT];
            // RULE2 slot and half
            CHAN8_SLOT_INDEX        <= chan8_reg[5:0];
            CHAN8_RIGHT_HALF        <= chan8_reg[5];
            // RULE5 automatic derivation
            AUTO_CLOCK_ACTIVE       <= auto_on;
            // RULE6 auto PLL control
            PLL_ENABLE              <= auto_on && !auto_pll_off;
            // RULE8 rate family
            RATE_FAMILY_SELECT      <= role_ctrl && role_reg[asc_pkg::RATE_FAMILY_BIT];
            // RULE9 RULE15 reference selection
            REF_BY_FREQ_CODE        <= role_ctrl && !root_reg[asc_pkg::SELECT_METHOD_BIT];
            REF_CLOCK_FREQ_CODE     <= role_reg[2:0];
            // RULE10 RULE11 ignored in target auto
            RATE_RATIO_USED         <= role_ctrl || !auto_on;
            FRAME_RATE_CODE         <= rate_ratio_reg[7:4];
            BITCLK_FRAME_RATIO_CODE <= ratio_field;
            // RULE16 root source
            ROOT_FROM_REF           <= !role_ctrl && auto_on && auto_pll_off
                                       && root_reg[asc_pkg::ROOT_SOURCE_BIT];
        end
    end

    // =========================================================================
    // Serial clock generator
    // =========================================================================
    logic [7:0]  half_cnt_reg;
    logic [11:0] bit_cnt_reg;
    logic        bclk_gen_reg;
    wire  [3:0]  gen_ratio   = ratio_lookup(asc_pkg::RATIO_VAL[0]) == 4'h0 && ratio_field
                               < 4'(asc_pkg::RATIO_CODES) ? ratio_field : asc_pkg::FALLBACK_RATIO;
    wire  [11:0] frame_len   = asc_pkg::RATIO_VAL[gen_ratio];
    wire         half_done   = half_cnt_reg == asc_pkg::BCLK_HALF_CYCLES - 8'h01;
    wire         fall_edge   = half_done && bclk_gen_reg;
    wire         drive_pins  = role_ctrl;
    wire         gate_now    = clock_gate;

    // Divider and frame counter run only in controller role.
    always_ff @(posedge CLK) begin
        if (RESET || !role_ctrl) begin
            half_cnt_reg <= 8'h00;
            bit_cnt_reg  <= 12'h000;
            bclk_gen_reg <= 1'b0;
        end else if (CE) begin
            half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
            if (half_done) bclk_gen_reg <= !bclk_gen_reg;
            if (fall_edge) bit_cnt_reg <= bit_cnt_reg >= frame_len - 12'h001 ? 12'h000 : bit_cnt_reg + 12'h001;
        end
    end

    // Pin drivers.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BCLK_O        <= 1'b0;
            BCLK_OE       <= 1'b0;
            FRAME_SYNC_O  <= 1'b0;
            FRAME_SYNC_OE <= 1'b0;
        end else if (CE) begin
            // RULE4 RULE18 pin direction
            BCLK_OE       <= drive_pins;
            FRAME_SYNC_OE <= drive_pins;
            // RULE7 forced gating
            BCLK_O        <= drive_pins && !gate_now && bclk_gen_reg;
            FRAME_SYNC_O  <= drive_pins && !gate_now && bit_cnt_reg == 12'h000;
        end
    end

    // =========================================================================
    // Clock monitor
    // =========================================================================
    logic        bclk_s1, bclk_s2, bclk_s3;
    logic        fs_s1, fs_s2, fs_s3;
    logic [15:0] period_cnt_reg;
    logic [11:0] bclk_cnt_reg;
    wire         fs_rise   = fs_s2 && !fs_s3;
    wire         bclk_rise = bclk_s2 && !bclk_s3;
    wire         timed_out = period_cnt_reg == asc_pkg::FRAME_TIMEOUT;

    // Pin synchronisers.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
            {fs_s1, fs_s2, fs_s3}       <= 3'h0;
        end else if (CE) begin
            {bclk_s1, bclk_s2, bclk_s3} <= {BCLK_I, bclk_s1, bclk_s2};
            {fs_s1, fs_s2, fs_s3}       <= {FRAME_SYNC_I, fs_s1, fs_s2};
        end
    end

    // Frame measurement; a stopped bus reports all invalid.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            period_cnt_reg <= 16'h0000;
            bclk_cnt_reg   <= 12'h000;
            status_reg     <= asc_pkg::PORT_CLOCK_MONITOR_STATUS_RST;
        end else if (CE) begin
            if (fs_rise) begin
                period_cnt_reg <= 16'h0001;
                bclk_cnt_reg   <= {11'h000, bclk_rise};
                // RULE13 RULE14 detected codes
                status_reg     <= {rate_lookup(period_cnt_reg), ratio_lookup(bclk_cnt_reg)};
            end else if (timed_out) begin
                status_reg     <= asc_pkg::PORT_CLOCK_MONITOR_STATUS_RST;
            end else begin
                period_cnt_reg <= period_cnt_reg + 16'h0001;
                if (bclk_rise && bclk_cnt_reg != 12'hfff) bclk_cnt_reg <= bclk_cnt_reg + 12'h001;
            end
        end
    end

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET || !CE);

    sequence s_role_write(bit v);
        wr_role && REG_WDATA[asc_pkg::ROLE_SELECT_BIT] == v;
    endsequence
    sequence s_two_edges;
        ##2 1'b1;
    endsequence

    AST_TARGET_INPUTS: assert property (s_role_write(1'b0) |-> s_two_edges ##0 (!BCLK_OE && !FRAME_SYNC_OE)) // RULE18
        else $error("Clock pins driven in target role.");
    AST_CTRL_DRIVES: assert property (s_role_write(1'b1) |-> s_two_edges ##0 (BCLK_OE && FRAME_SYNC_OE)) // RULE4
        else $error("Controller role does not drive clocks.");
    AST_GATE_LOW: assert property ($past(clock_gate) && $past(role_ctrl) |-> !BCLK_O && !FRAME_SYNC_O) // RULE7
        else $error("Gated clocks still toggle.");
    AST_PLL_FOLLOWS: assert property (wr_role |-> ##2 PLL_ENABLE == (!$past(REG_WDATA[6], 2) && !$past(REG_WDATA[5], 2))) // RULE6
        else $error("PLL enable does not follow auto settings.");
    AST_AUTO_FLAG: assert property (wr_role |-> ##2 AUTO_CLOCK_ACTIVE != $past(REG_WDATA[6], 2)) // RULE5
        else $error("Auto configuration flag wrong.");
    AST_CHAN8_RESERVED: assert property (wr_chan8 |=> !chan8_reg[7] && chan8_reg[6:0] == $past(REG_WDATA[6:0])) // RULE17
        else $error("Channel 8 register stores reserved bit.");
    AST_LINE_SEL: assert property (wr_chan8 |-> ##2 CHAN8_LINE_SELECT == $past(REG_WDATA[6], 2)) // RULE1
        else $error("Line select output wrong.");
    AST_RIGHT_HALF: assert property (wr_chan8 |-> ##2 CHAN8_RIGHT_HALF == ($past(REG_WDATA[5:0], 2) > 6'h1f)) // RULE2
        else $error("Right half flag does not match slot code.");
    AST_STATUS_RO: assert property (REG_WE && REG_ADDR == asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR && !fs_rise
                                    && !timed_out |=> $stable(status_reg)) // RULE12
        else $error("Status register changed by a write.");
    AST_TIMEOUT_FF: assert property (timed_out && !fs_rise |=> status_reg == 8'hff) // RULE13
        else $error("Stopped bus not reported invalid.");
    AST_RATIO_CODE: assert property (fs_rise && bclk_cnt_reg == 12'h010 |=> status_reg[3:0] == 4'h0) // RULE14
        else $error("Ratio 16 not reported as code 0.");
    AST_IGNORED: assert property (wr_role && !REG_WDATA[7] && !REG_WDATA[6] |-> ##2 !RATE_RATIO_USED) // RULE10
        else $error("Rate fields used in target auto mode.");

endmodule : asc_port_config

// ---- asc_host_model.sv ----
// Host-side clock source for the audio serial port while the device is target.
// Assumes the bench enables it only while the device clock pins are inputs.
`timescale 1ns/1ps

module asc_host_model #(
    parameter int HALF_NS = 160,
    parameter int BITS    = 16
) (
    // Control
    input  wire logic en,
    // Serial clock pins
    output logic      bclk,
    output logic      frame_sync
);
    // =========================================================================
    // Clock generation
    // =========================================================================
    // host drives clocks
    // Clocks stand still between frames once disabled, so no stray edge is seen.
    initial begin
        bclk  = 1'b0;
        frame_sync = 1'b0;
        forever begin
            wait (en);
            for (int i = 0; i < BITS; i++) begin
                frame_sync = (i == 0);
                #(HALF_NS) bclk = 1'b1;
                #(HALF_NS) bclk = 1'b0;
            end
        end
    end
endmodule : asc_host_model

// ---- asc_port_config_bench.sv ----
// Self-checking bench for the audio port register file, clock generator and monitor.
// Assumes the host model supplies target-role clocks of 16 bits at 512 cycles a frame.
`timescale 1ns/1ps

module asc_port_config_bench;
    // =========================================================================
    // Signals
    // =========================================================================
    logic       clk, reset, ce, reg_we, host_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       bclk_o, bclk_oe, fs_o, fs_oe, host_bclk, host_fs;
    logic       line_sel, right_half, auto_on, pll_en, fam, by_freq, rr_used, root_ref;
    logic [5:0] slot;
    logic [2:0] ref_code;
    logic [3:0] rate_code, ratio_code;
    int         error_cnt, checks_done, cyc;

    // Wire level of the shared clock pins from both drivers.
    wire bclk_pin = bclk_oe ? bclk_o : host_bclk;
    wire fs_pin   = fs_oe ? fs_o : host_fs;

    asc_host_model asc_host_model_i (.en(host_en), .bclk(host_bclk), .frame_sync(host_fs));

    asc_port_config asc_port_config_i (
        .CLK(clk), .RESET(reset), .CE(ce), .REG_ADDR(reg_addr), .REG_WE(reg_we),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .BCLK_I(bclk_pin), .BCLK_O(bclk_o),
        .BCLK_OE(bclk_oe), .FRAME_SYNC_I(fs_pin), .FRAME_SYNC_O(fs_o), .FRAME_SYNC_OE(fs_oe),
        .CHAN8_LINE_SELECT(line_sel), .CHAN8_SLOT_INDEX(slot), .CHAN8_RIGHT_HALF(right_half),
        .AUTO_CLOCK_ACTIVE(auto_on), .PLL_ENABLE(pll_en), .RATE_FAMILY_SELECT(fam),
        .REF_BY_FREQ_CODE(by_freq), .REF_CLOCK_FREQ_CODE(ref_code), .RATE_RATIO_USED(rr_used),
        .FRAME_RATE_CODE(rate_code), .BITCLK_FRAME_RATIO_CODE(ratio_code), .ROOT_FROM_REF(root_ref));

    // =========================================================================
    // Clock, reset and timeout
    // =========================================================================
    // Clock toggles every half period of 5 ns.
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Cuts a hang short; the monitor stall test alone needs about 66000 cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("unexpected timeout expected 0 seen 1");
            summarize();
        end
    end

    // =========================================================================
    // Shared tasks
    // =========================================================================
    // Compares one byte-wide result and counts it.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Writes one register with a single-cycle strobe, then lets outputs settle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(negedge clk);
        reg_we    = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr

    // Reads one register; data is registered one edge after the address.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk($sformatf("read of %h", a), exp, reg_rdata);
    endtask : rd

    // Measures cycles and generated bit clocks between two frame sync rises.
    task automatic fs_period(input int exp);
        int n;
        int t0;
        int rises;
        int bits;
        logic last;
        logic last_b;
        n = 0; t0 = 0; rises = 0; bits = 0; last = fs_o; last_b = bclk_o;
        for (int i = 0; i < 3000 && rises < 2; i++) begin
            @(negedge clk);
            if (rises == 1 && bclk_o && !last_b) bits++;
            if (fs_o && !last) begin
                rises++;
                if (rises == 1) t0 = i;
                else n = i - t0;
            end
            last = fs_o;
            last_b = bclk_o;
        end
        chk("frame period", 8'(exp), 8'(n));
        chk("bit clocks per frame", 8'(exp / 4), 8'(bits));
    endtask : fs_period

    // =========================================================================
    // Scenarios
    // =========================================================================
    // Reset values of every register but the root register at 0x16, an unmapped place and decoded outputs.
    task automatic t_reset;
        rd(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'h07);
        rd(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h02);
        rd(asc_pkg::PORT_RATE_RATIO_CONFIG_ADDR, 8'h48);
        rd(asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR, 8'hff);
        rd(8'h3a, 8'h00);
        chk("pins", 8'hc2, {auto_on, pll_en, 1'b0, bclk_oe, fs_oe, ref_code});
        chk("codes", 8'h48, {rate_code, ratio_code});
    endtask : t_reset

    // Slot field, line select, right half and the reserved top bit.
    task automatic t_chan8;
        wr(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'hff);
        rd(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'h7f);
        chk("chan8 out", 8'hff, {line_sel, right_half, slot});
        wr(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'h1f);
        chk("chan8 left", 8'h1f, {line_sel, right_half, slot});
        ce = 1'b0;
        wr(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'h20);
        ce = 1'b1;
        rd(asc_pkg::CHAN8_SLOT_CONFIG_ADDR, 8'h1f);
        wr(asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR, 8'h00);
        rd(asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR, 8'hff);
    endtask : t_chan8

    // Controller role: frame length for ratio codes 0 and 2, gating and family bit.
    task automatic t_controller;
        int r;
        r = 0;
        wr(asc_pkg::PORT_RATE_RATIO_CONFIG_ADDR, 8'h80);
        chk("codes", 8'h80, {rate_code, ratio_code});
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h8a);
        chk("ctrl oe", 8'h03, {6'h0, bclk_oe, fs_oe});
        chk("family", 8'h1a, {3'h0, fam, by_freq, ref_code});
        fs_period(64);
        wr(asc_pkg::PORT_RATE_RATIO_CONFIG_ADDR, 8'h82);
        fs_period(128);
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h90);
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            r += (bclk_o | fs_o);
        end
        chk("gated activity", 8'h00, {7'h0, r != 0});
        chk("gated oe", 8'h03, {6'h0, bclk_oe, fs_oe});
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h18);
        chk("target", 8'h00, {4'h0, bclk_oe, fs_oe, fam, rr_used});
    endtask : t_controller

    // Automatic mode, PLL and root clock selection.
    task automatic t_auto;
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h40);
        chk("auto off", 8'h01, {5'h0, auto_on, pll_en, rr_used});
        wr(asc_pkg::CLOCK_ROOT_CONFIG_ADDR, 8'hff);
        rd(asc_pkg::CLOCK_ROOT_CONFIG_ADDR, 8'hc0);
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h20);
        chk("pll off", 8'h09, {4'h0, auto_on, pll_en, by_freq, root_ref});
        wr(asc_pkg::CLOCK_ROOT_CONFIG_ADDR, 8'h00);
        chk("root bclk", 8'h00, {7'h0, root_ref});
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h80);
        chk("by freq", 8'h03, {6'h0, by_freq, pll_en});
        wr(asc_pkg::PORT_ROLE_CLOCK_CONFIG_ADDR, 8'h00);
    endtask : t_auto

    // Monitor: 512-cycle frames of 16 bit clocks, then a stall past the timeout.
    task automatic t_monitor;
        host_en = 1'b1;
        repeat (1800) @(negedge clk);
        rd(asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR, 8'h60);
        host_en = 1'b0;
        repeat (66000) @(negedge clk);
        rd(asc_pkg::PORT_CLOCK_MONITOR_STATUS_ADDR, 8'hff);
    endtask : t_monitor

    // Prints counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        reset = 1'b1; ce = 1'b1; reg_we = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        host_en = 1'b0; error_cnt = 0; checks_done = 0; cyc = 0;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_chan8();
        t_controller();
        t_auto();
        t_monitor();
        summarize();
    end
endmodule : asc_port_config_bench
